// >>> design/mif_combiner.sv
/*
  Multi-input function combiner: four selectable inputs, per-input inversion and scale,
  a chain of three binary operators, output scale and clip, behind an AXI4-Lite slave.
  Sources present signed fixed-point values (24 fraction bits), normally in 0..1,
  synchronous to i_ref_clk.
*/
`timescale 1ns/1ps
module mif_combiner
  import mif_pkg::*;
#(
  parameter int N_SRC        = 8,           // Number of selectable sources.
  parameter int P_EVAL_CYCLE = EVAL_CYCLES  // Reset value of the interval register.
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  input  wire logic [N_SRC-1:0][31:0] i_src_val,
  input  wire logic [7:0]            i_s_axi_awaddr,
  input  wire logic                  i_s_axi_awvalid,
  output logic                       o_s_axi_awready,
  input  wire logic [31:0]           i_s_axi_wdata,
  input  wire logic [3:0]            i_s_axi_wstrb,
  input  wire logic                  i_s_axi_wvalid,
  output logic                       o_s_axi_wready,
  output logic [1:0]                 o_s_axi_bresp,
  output logic                       o_s_axi_bvalid,
  input  wire logic                  i_s_axi_bready,
  input  wire logic [7:0]            i_s_axi_araddr,
  input  wire logic                  i_s_axi_arvalid,
  output logic                       o_s_axi_arready,
  output logic [31:0]                o_s_axi_rdata,
  output logic [1:0]                 o_s_axi_rresp,
  output logic                       o_s_axi_rvalid,
  input  wire logic                  i_s_axi_rready,
  output logic [31:0]                o_result,
  output logic                       o_avail,
  output logic                       o_update
);
  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  // The source field is eight bits wide with code zero reserved.
  if (N_SRC < 1 || N_SRC > 255) begin : g_bad_nsrc
    $error("N_SRC must lie in 1..255");
  end

  // ---------------------------------------------------------------
  // Arithmetic helpers
  // ---------------------------------------------------------------
  // Saturate a 64-bit value to 32 bits so overflow never wraps sign.
  function automatic logic [31:0] sat64(input logic signed [63:0] v);
    if (v > 64'sh0000_0000_7fff_ffff) begin
      sat64 = Q_MAX;
    end else if (v < -64'sh0000_0000_8000_0000) begin
      sat64 = Q_MIN;
    end else begin
      sat64 = v[31:0];
    end
  endfunction

  // Fixed-point multiply with saturation.
  function automatic logic [31:0] mulq(input logic [31:0] a, input logic [31:0] b);
    logic signed [63:0] p;
    p = $signed(a) * $signed(b);
    mulq = sat64(p >>> FRAC_BITS);
  endfunction

  // Larger of a value and delta, so the divider never sees zero or negatives.
  function automatic logic [31:0] floor_d(input logic [31:0] v);
    floor_d = ($signed(v) < $signed(Q_DELTA)) ? Q_DELTA : v;
  endfunction

  // All operators but division, which runs on the sequential divider.
  function automatic logic [31:0] apply_fn(input logic [3:0] f, input logic [31:0] x,
                                           input logic [31:0] y);
    logic signed [32:0] sx;
    logic signed [32:0] sy;
    logic signed [32:0] dif;
    logic               tx;
    logic               ty;
    logic               res;
    sx  = {x[31], x};
    sy  = {y[31], y};
    dif = sx - sy;
    tx  = $signed(x) >= $signed(Q_HALF);
    ty  = $signed(y) >= $signed(Q_HALF);
    res = 1'b0;
    apply_fn = sat64(64'(sx + sy));
    case (f)
      FN_MUL: apply_fn = mulq(x, y);
      FN_MAX: apply_fn = ($signed(x) > $signed(y)) ? x : y;
      FN_MIN: apply_fn = ($signed(x) < $signed(y)) ? x : y;
      FN_OR, FN_AND, FN_XOR, FN_LT, FN_LE, FN_EQ, FN_GT, FN_GE: begin
        case (f)
          FN_OR:   res = tx | ty;
          FN_AND:  res = tx & ty;
          FN_XOR:  res = tx ^ ty;
          FN_LT:   res = dif < 0;
          FN_LE:   res = dif <= $signed({1'b0, Q_DELTA});
          FN_EQ:   res = (dif <= $signed({1'b0, Q_DELTA})) &&
                         (dif >= -$signed({1'b0, Q_DELTA}));
          FN_GT:   res = dif > 0;
          default: res = dif >= -$signed({1'b0, Q_DELTA});
        endcase
        apply_fn = res ? Q_ONE : 32'h0000_0000;
      end
      default: ;  // Add, and unused codes fall back to add.
    endcase
  endfunction

  // Byte-lane merge of an AXI write.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0]  period_r;        // Evaluation interval in clocks.
  logic [31:0]  cfg_r [4];       // Input configuration words.
  logic [31:0]  scale_r [4];     // Input scale coefficients.
  logic [31:0]  oscale_r;        // Output scale coefficient.
  mif_cfg_s     cfg [4];         // Decoded configuration.
  logic         aw_hold_r;       // Write address captured.
  logic         w_hold_r;        // Write data captured.
  logic [7:0]   awaddr_r;        // Captured write address.
  logic [31:0]  wdata_r;         // Captured write data.
  logic [3:0]   wstrb_r;         // Captured byte enables.
  logic         busy;            // Sequencer running.

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cfg[i] = '{fn:  cfg_r[i][CFG_FN_LSB +: 4], inv: cfg_r[i][CFG_INV_BIT],
                 src: cfg_r[i][CFG_SRC_LSB +: 8]};
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  // Address and data are taken in either order; the response issues once both are held.
  // Only one write is in flight, so ready drops while a response is pending.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      aw_hold_r       <= 1'b0;
      w_hold_r        <= 1'b0;
      awaddr_r        <= 8'h00;
      wdata_r         <= 32'h0000_0000;
      wstrb_r         <= 4'h0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready  <= 1'b0;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= AXI_OKAY;
      period_r        <= 32'(P_EVAL_CYCLE);
      oscale_r        <= Q_ONE;
      for (int i = 0; i < 4; i++) begin
        cfg_r[i]   <= CFG_RST;
        scale_r[i] <= Q_ONE;
      end
    end else begin
      o_s_axi_awready <= !aw_hold_r && !o_s_axi_bvalid && !o_s_axi_awready;
      o_s_axi_wready  <= !w_hold_r && !o_s_axi_bvalid && !o_s_axi_wready;
      if (o_s_axi_awready && i_s_axi_awvalid) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= i_s_axi_awaddr;
      end
      if (o_s_axi_wready && i_s_axi_wvalid) begin
        w_hold_r <= 1'b1;
        wdata_r  <= i_s_axi_wdata;
        wstrb_r  <= i_s_axi_wstrb;
      end
      if (aw_hold_r && w_hold_r && !o_s_axi_bvalid) begin
        aw_hold_r      <= 1'b0;
        w_hold_r       <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= AXI_OKAY;
        // Writes to the live registers are refused with an error, other holes too.
        if (awaddr_r[7:2] == OFS_PERIOD[7:2]) begin
          period_r <= merge(period_r, wdata_r, wstrb_r);
        end else if (awaddr_r[7:2] == OFS_OSCALE[7:2]) begin
          oscale_r <= merge(oscale_r, wdata_r, wstrb_r);
        end else if (awaddr_r >= OFS_CFG0 && awaddr_r < OFS_SCALE0) begin
          cfg_r[2'(awaddr_r[7:2] - OFS_CFG0[7:2])] <=
            merge(cfg_r[2'(awaddr_r[7:2] - OFS_CFG0[7:2])], wdata_r, wstrb_r);
        end else if (awaddr_r >= OFS_SCALE0 && awaddr_r < OFS_OSCALE) begin
          scale_r[2'(awaddr_r[7:2] - OFS_SCALE0[7:2])] <=
            merge(scale_r[2'(awaddr_r[7:2] - OFS_SCALE0[7:2])], wdata_r, wstrb_r);
        end else begin
          o_s_axi_bresp <= AXI_SLVERR;
        end
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  // Data answer one clock after the address is taken.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= AXI_OKAY;
    end else begin
      o_s_axi_arready <= !o_s_axi_rvalid && !o_s_axi_arready;
      if (o_s_axi_arready && i_s_axi_arvalid) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rresp  <= AXI_OKAY;
        o_s_axi_rdata  <= 32'h0000_0000;
        if (i_s_axi_araddr[7:2] == OFS_PERIOD[7:2]) begin
          o_s_axi_rdata <= period_r;
        end else if (i_s_axi_araddr[7:2] == OFS_OSCALE[7:2]) begin
          o_s_axi_rdata <= oscale_r;
        end else if (i_s_axi_araddr[7:2] == OFS_STATUS[7:2]) begin
          o_s_axi_rdata <= {30'h0, busy, o_avail};
        end else if (i_s_axi_araddr[7:2] == OFS_RESULT[7:2]) begin
          o_s_axi_rdata <= o_result;
        end else if (i_s_axi_araddr >= OFS_CFG0 && i_s_axi_araddr < OFS_SCALE0) begin
          o_s_axi_rdata <= cfg_r[2'(i_s_axi_araddr[7:2] - OFS_CFG0[7:2])];
        end else if (i_s_axi_araddr >= OFS_SCALE0 && i_s_axi_araddr < OFS_OSCALE) begin
          o_s_axi_rdata <= scale_r[2'(i_s_axi_araddr[7:2] - OFS_SCALE0[7:2])];
        end else begin
          o_s_axi_rresp <= AXI_SLVERR;
        end
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Input selection, inversion and scaling
  // ---------------------------------------------------------------
  logic [3:0]  conn;       // Input has a live source.
  logic [31:0] scaled [4]; // Scaled operand of each input.

  always_comb begin
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      conn[i] = (cfg[i].src != 8'h00) && (32'(cfg[i].src) <= N_SRC);
      v       = conn[i] ? i_src_val[8'(cfg[i].src - 8'h01)] : 32'h0000_0000;
      if (cfg[i].inv) begin
        v = Q_ONE - v;
      end
      scaled[i] = mulq(v, scale_r[i]);
    end
  end

  // ---------------------------------------------------------------
  // Evaluation sequencer
  // ---------------------------------------------------------------
  mif_state_e   state_r;      // Sequencer state.
  logic [31:0]  tick_r;       // Interval counter.
  logic [31:0]  opd_r [4];    // Operands frozen for this evaluation.
  logic [31:0]  acc_r;        // Running chain result.
  logic [1:0]   stage_r;      // Operand index being combined, 1..3.
  logic [1:0]   last_r;       // Last operand index of the truncated chain.
  logic         ok_r;         // Inputs one and two both connected.
  logic [55:0]  div_q_r;      // Shifting dividend, then quotient.
  logic [32:0]  div_rem_r;    // Partial remainder.
  logic [31:0]  div_den_r;    // Divisor.
  logic [5:0]   div_cnt_r;    // Divider steps left.
  logic [32:0]  rem_sh;       // Remainder after shifting in the next bit.
  logic [31:0]  div_res;      // Saturated quotient.
  logic [31:0]  fin;          // Scaled final value before clipping.

  assign busy    = (state_r != ST_IDLE);
  assign rem_sh  = {div_rem_r[31:0], div_q_r[55]};
  assign div_res = (|div_q_r[55:31]) ? Q_MAX : div_q_r[31:0];
  assign fin     = mulq(acc_r, oscale_r);

  // One evaluation per interval; the result register holds between updates.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_r   <= ST_IDLE;
      tick_r    <= 32'h0000_0000;
      acc_r     <= 32'h0000_0000;
      stage_r   <= 2'h1;
      last_r    <= 2'h1;
      ok_r      <= 1'b0;
      div_q_r   <= 56'h0;
      div_rem_r <= 33'h0;
      div_den_r <= Q_DELTA;
      div_cnt_r <= 6'h0;
      o_result  <= 32'h0000_0000;
      o_avail   <= 1'b0;
      o_update  <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        opd_r[i] <= 32'h0000_0000;
      end
    end else begin
      o_update <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          tick_r <= tick_r + 32'h1;
          if (tick_r + 32'h1 >= period_r) begin
            tick_r  <= 32'h0000_0000;
            state_r <= ST_SCALE;
          end
        end
        ST_SCALE: begin
          for (int i = 0; i < 4; i++) begin
            opd_r[i] <= scaled[i];
          end
          acc_r   <= scaled[0];
          stage_r <= 2'h1;
          ok_r    <= conn[0] && conn[1];
          // A missing third input ends the chain even if the fourth is wired.
          last_r  <= !conn[2] ? 2'h1 : (!conn[3] ? 2'h2 : 2'h3);
          state_r <= ST_OP;
        end
        ST_OP: begin
          if (cfg[stage_r].fn == FN_DIV) begin
            div_q_r   <= {floor_d(acc_r), 24'h0};
            div_den_r <= floor_d(opd_r[stage_r]);
            div_rem_r <= 33'h0;
            div_cnt_r <= 6'(DIV_STEPS);
            state_r   <= ST_DIV;
          end else begin
            acc_r   <= apply_fn(cfg[stage_r].fn, acc_r, opd_r[stage_r]);
            stage_r <= stage_r + 2'h1;
            state_r <= (stage_r == last_r) ? ST_OUT : ST_OP;
          end
        end
        ST_DIV: begin
          // Restoring division, one quotient bit per clock.
          if (div_cnt_r != 6'h0) begin
            div_cnt_r <= div_cnt_r - 6'h1;
            if (rem_sh >= {1'b0, div_den_r}) begin
              div_rem_r <= rem_sh - {1'b0, div_den_r};
              div_q_r   <= {div_q_r[54:0], 1'b1};
            end else begin
              div_rem_r <= rem_sh;
              div_q_r   <= {div_q_r[54:0], 1'b0};
            end
          end else begin
            acc_r   <= div_res;
            stage_r <= stage_r + 2'h1;
            state_r <= (stage_r == last_r) ? ST_OUT : ST_OP;
          end
        end
        ST_OUT: begin
          o_avail  <= ok_r;
          o_update <= 1'b1;
          if (!ok_r || $signed(fin) < 0) begin
            o_result <= 32'h0000_0000;
          end else if ($signed(fin) > $signed(Q_ONE)) begin
            o_result <= Q_ONE;
          end else begin
            o_result <= fin;
          end
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// >>> dv/mif_combiner_chk.sv
/*
  Checker of the combiner's output and bus timing, bound to the top module.
  Assumes the port names of mif_combiner and one clock domain.
*/
`timescale 1ns/1ps
module mif_combiner_chk
  import mif_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  input wire logic        i_s_axi_arvalid,
  input wire logic        i_s_axi_bready,
  input wire logic        i_s_axi_rready,
  input wire logic        o_s_axi_arready,
  input wire logic        o_s_axi_bvalid,
  input wire logic [1:0]  o_s_axi_bresp,
  input wire logic        o_s_axi_rvalid,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [31:0] o_result,
  input wire logic        o_avail,
  input wire logic        o_update
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  chk_result_clip: assert property (o_result <= Q_ONE)
    else $error("result outside zero to one");
  chk_unavail_zero: assert property (!o_avail |-> o_result == 32'h0)
    else $error("unavailable output is not zero");
  chk_update_pulse: assert property (o_update |=> !o_update)
    else $error("update pulse longer than one cycle");
  chk_result_hold: assert property (!o_update |-> $stable(o_result))
    else $error("result changed without update");
  chk_avail_hold: assert property (!o_update |-> $stable(o_avail))
    else $error("availability changed without update");
  chk_bresp_stand: assert property (o_s_axi_bvalid && !i_s_axi_bready
    |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_stand: assert property (o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped early");
  chk_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  chk_ar_blocked: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read address accepted while data pending");
  cov_avail: cover property (o_update && o_avail);
  cov_unavail: cover property (o_update && !o_avail);
  cov_slverr: cover property (o_s_axi_bvalid && o_s_axi_bresp == AXI_SLVERR);
endmodule
bind mif_combiner mif_combiner_chk i_chk (.i_ref_clk, .i_rst_n, .i_s_axi_arvalid,
  .i_s_axi_bready, .i_s_axi_rready, .o_s_axi_arready, .o_s_axi_bvalid, .o_s_axi_bresp,
  .o_s_axi_rvalid, .o_s_axi_rdata, .o_result, .o_avail, .o_update);

// >>> dv/mif_src_model.sv
/*
  Model of the functional blocks that feed the combiner with normalized values.
  Assumes the bench sets the next value of every source and one shared clock.
*/
`timescale 1ns/1ps
module mif_src_model
  import mif_pkg::*;
#(
  parameter int N_SRC = 8  // Number of sources offered.
) (
  input  wire logic                   i_ref_clk,
  input  wire logic [N_SRC-1:0][31:0] i_next_val,
  output logic      [N_SRC-1:0][31:0] o_src_val
);
  // Real blocks update their outputs on the clock, so values move only after an edge.
  always_ff @(posedge i_ref_clk) begin
    o_src_val <= i_next_val;
  end
endmodule

// >>> dv/multi_input_function_combiner_tb_top.sv
/*
  Self-checking bench of the combiner: register defaults, bus refusals, every operator
  at its thresholds, then random chains. Assumes the partner model feeds the sources.
*/
`timescale 1ns/1ps
module multi_input_function_combiner_tb_top;
  import mif_pkg::*;
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, awr, wr_r, bv, arr, rv, av, upd;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd_v, res, got;
  logic [1:0] br, rr, resp;
  logic [7:0][31:0] nxt = '0, srcv;
  int err_total = 0, samples_checked = 0;
  int sel[4], inv[4], op[4];  // Per-input source, inversion and operator.
  longint scl[4], oscl, xv[4];  // Scales and values the bench expects to be used.
  always #25 i_ref_clk = ~i_ref_clk;  // 20 MHz.
  mif_src_model #(.N_SRC(8)) i_src (.i_ref_clk(i_ref_clk), .i_next_val(nxt), .o_src_val(srcv));
  // A short interval keeps every evaluation within a few dozen clocks.
  mif_combiner #(.N_SRC(8), .P_EVAL_CYCLE(40)) i_dut (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_src_val(srcv), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wr_r), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry),
    .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .o_s_axi_rdata(rd_v), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry),
    .o_result(res), .o_avail(av), .o_update(upd));
  task automatic check(string what, logic [32:0] seen, logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge i_ref_clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
    do begin
      @(posedge i_ref_clk);
      if (awv && awr) awv <= 0;
      if (wv && wr_r) wv <= 0;
    end while (!bv);
    resp = br; bry <= 0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge i_ref_clk);
    ara <= a; arv <= 1; rry <= 1;
    do begin
      @(posedge i_ref_clk);
      if (arv && arr) arv <= 0;
    end while (!rv);
    got = rd_v; resp = rr; rry <= 0;
  endtask
  // An evaluation in flight may use old settings, so the second pulse is the one judged.
  task automatic wait_upd();
    repeat (2) do @(posedge i_ref_clk); while (!upd);
  endtask
  function automatic longint f_op(int o, longint x, longint y);
    longint one = Q_ONE, d = Q_DELTA, h = Q_HALF;  // Signed copies keep compares signed.
    case (o)
      1: return (x * y) >>> 24;
      2: return ((x > d ? x : d) <<< 24) / (y > d ? y : d);
      3: return x > y ? x : y;
      4: return x < y ? x : y;
      5: return ((x >= h) || (y >= h)) ? one : 0;
      6: return ((x >= h) && (y >= h)) ? one : 0;
      7: return ((x >= h) != (y >= h)) ? one : 0;
      8: return x < y ? one : 0;
      9: return x <= y + d ? one : 0;
      10: return (x - y <= d && y - x <= d) ? one : 0;
      11: return x > y ? one : 0;
      12: return x >= y - d ? one : 0;
      default: return x + y;
    endcase
  endfunction
  function automatic logic [32:0] f_expect();
    longint v[4], acc, one = Q_ONE;  // A signed 1.0 keeps negative scales signed.
    if (sel[0] == 0 || sel[1] == 0) return 33'h0;
    for (int i = 0; i < 4; i++) v[i] = ((inv[i] ? one - xv[i] : xv[i]) * scl[i]) >>> 24;
    acc = f_op(op[1], v[0], v[1]);
    if (sel[2] != 0) begin
      acc = f_op(op[2], acc, v[2]);
      if (sel[3] != 0) acc = f_op(op[3], acc, v[3]);
    end
    acc = (acc * oscl) >>> 24;
    return {1'b1, acc < 0 ? 32'h0 : (acc > Q_ONE ? Q_ONE : 32'(acc))};
  endfunction
  // Program all inputs, present the values, and compare pins and register.
  task automatic run_case();
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CFG0 + 8'(4 * i), 32'((op[i] << 12) | (inv[i] << 8) | sel[i]));
      wr(OFS_SCALE0 + 8'(4 * i), 32'(scl[i]));
      nxt[i] <= 32'(xv[i]);
    end
    wr(OFS_OSCALE, 32'(oscl));
    wait_upd();
    check("result pins", {av, res}, f_expect());
    rd(OFS_RESULT);
    check("result reg", {1'b0, got}, {1'b0, f_expect() & 33'hffffffff});
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge i_ref_clk);
    err_total++;
    conclude();
  end
  initial begin
    longint pr[5][2] = '{'{32'h0080_0000, 32'h0080_0000}, '{32'h0080_0000, 32'h007f_ffef},
      '{32'h0080_0000, 32'h007f_ffee}, '{32'h0040_0000, Q_ONE}, '{0, 0}};
    void'($urandom(32'h8c09efe2));
    repeat (10) @(posedge i_ref_clk);
    i_rst_n <= 1;
    rd(OFS_PERIOD); check("period", got, 40);
    for (int i = 0; i < 4; i++) begin
      rd(OFS_CFG0 + 8'(4 * i)); check("cfg", got, CFG_RST);
      rd(OFS_SCALE0 + 8'(4 * i)); check("scale", got, Q_ONE);
    end
    rd(OFS_OSCALE); check("oscale", got, Q_ONE);
    wait_upd(); check("idle out", {av, res}, 33'h0);
    rd(OFS_STATUS); check("status", got, 33'h0);
    wr(OFS_RESULT, 32'h0000_0005); check("ro write", resp, AXI_SLVERR);
    rd(8'h30); check("unmapped resp", resp, AXI_SLVERR);
    check("unmapped data", got, 33'h0);
    wr(OFS_PERIOD, 32'h8); rd(OFS_PERIOD); check("period", got, 8);
    $display("test defaults_and_bus done");
    // Every operator at and around the truth and tolerance thresholds.
    sel = '{1, 2, 0, 4}; inv = '{0, 0, 0, 0}; scl = '{Q_ONE, Q_ONE, Q_ONE, Q_ONE};
    oscl = Q_ONE;
    for (int p = 0; p < 5; p++) for (int o = 0; o < 16; o++) begin
      op = '{0, o, 0, 1}; xv = '{pr[p][0], pr[p][1], 0, 0};
      run_case();
    end
    $display("test operator_table done");
    for (int n = 0; n < 40; n++) begin
      for (int i = 0; i < 4; i++) begin
        sel[i] = ($urandom_range(0, 5) == 0) ? 0 : i + 1;
        inv[i] = $urandom_range(0, 1);
        op[i] = $urandom_range(0, 15);
        if (op[i] == 2) op[i] = 3;
        scl[i] = $urandom_range(0, 2) == 0 ? 64'hffff_ffff_ff80_0000 :
          Q_ONE >> $urandom_range(0, 1);
        xv[i] = longint'($urandom_range(0, 16)) << 20;
      end
      oscl = Q_ONE << $urandom_range(0, 1);
      run_case();
    end
    $display("test random_chains done");
    conclude();
  end
endmodule

// >>> include/mif_pkg.sv
/*
  Constants, field layouts, reset values and types of the multi-input function combiner.
  It assumes a 20 MHz system clock and a signed fixed-point format with 24 fraction bits.
*/
// Contract
// - Each input selects a source, default not connected.
// - Per-input inversion complements value, default off.
// - Per-input scale coefficient, default one.
// - Second operation combines inputs one and two.
// - Third, fourth operations extend chain, default add.
// - Chain result multiplied by output scale.
// - Division raises both operands to delta first.
// - Logical operators treat half or above true.
// - Comparisons use delta tolerance, yield one/zero; the code applies no tolerance to less-than and greater-than.
// - Unconnected third or fourth input truncates chain.
// - Input one or two missing: unavailable, zero.
// - Result clipped into zero to one.
package mif_pkg;
  // ---------------------------------------------------------------
  // Number format
  // ---------------------------------------------------------------
  localparam int          FRAC_BITS = 24;             // Fraction bits of every value.
  localparam logic [31:0] Q_ONE     = 32'h0100_0000;  // 1.0, also the scale reset value.
  localparam logic [31:0] Q_HALF    = 32'h0080_0000;  // 0.5, truth threshold.
  localparam logic [31:0] Q_DELTA   = 32'h0000_0011;  // 1.0E-6 rounded up to whole LSBs.
  localparam logic [31:0] Q_MAX     = 32'h7fff_ffff;  // Saturation ceiling.
  localparam logic [31:0] Q_MIN     = 32'h8000_0000;  // Saturation floor.
  localparam int          DIV_STEPS = 56;             // Quotient bits of the divider.

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ       = 20000;                         // System clock rate.
  localparam int EVAL_TIME_US  = 1000;                          // Evaluation interval.
  localparam int EVAL_CYCLES   = EVAL_TIME_US * CLK_KHZ / 1000; // Interval in clocks.

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PERIOD   = 8'h00;  // Evaluation interval in clocks.
  localparam logic [7:0] OFS_CFG0     = 8'h04;  // Input configuration, four words.
  localparam logic [7:0] OFS_SCALE0   = 8'h14;  // Input scale, four words.
  localparam logic [7:0] OFS_OSCALE   = 8'h24;  // Output scale.
  localparam logic [7:0] OFS_STATUS   = 8'h28;  // Bit 0 available, bit 1 busy.
  localparam logic [7:0] OFS_RESULT   = 8'h2c;  // Last clipped result.

  // ---------------------------------------------------------------
  // Configuration word fields and reset values
  // ---------------------------------------------------------------
  localparam int          CFG_SRC_LSB  = 0;      // Source select, 0 = not connected.
  localparam int          CFG_INV_BIT  = 8;      // Inversion flag.
  localparam int          CFG_FN_LSB   = 12;     // Operator code.
  localparam logic [31:0] CFG_RST      = 32'h0000_0000;
  localparam logic [1:0]  AXI_OKAY     = 2'h0;
  localparam logic [1:0]  AXI_SLVERR   = 2'h2;

  // Operator codes of the chain.
  typedef enum logic [3:0] {
    FN_ADD = 4'h0, FN_MUL = 4'h1, FN_DIV = 4'h2, FN_MAX = 4'h3, FN_MIN = 4'h4,
    FN_OR  = 4'h5, FN_AND = 4'h6, FN_XOR = 4'h7, FN_LT  = 4'h8, FN_LE  = 4'h9,
    FN_EQ  = 4'ha, FN_GT  = 4'hb, FN_GE  = 4'hc
  } mif_fn_e;

  // Evaluation sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_SCALE = 3'b001, ST_OP = 3'b010, ST_DIV = 3'b011, ST_OUT = 3'b100
  } mif_state_e;

  // Decoded view of one input configuration word.
  typedef struct packed {
    logic [3:0] fn;   // Operator code.
    logic       inv;  // Inversion flag.
    logic [7:0] src;  // Source select.
  } mif_cfg_s;
endpackage
